// ==== dbgmc_pkg.sv ====
// Shared constants, types and encodings of the debug command engine
package dbgmc_pkg;

  localparam int FRAME_BITS = 17;
  localparam logic [4:0] FRAME_LAST = 5'h10;

  localparam logic [11:0] OP_RD_REG = 12'h218;
  localparam logic [11:0] OP_WR_REG = 12'h208;
  localparam logic [7:0] OP_MEM_RD = 8'h19;
  localparam logic [7:0] OP_MEM_WR = 8'h18;
  localparam logic [7:0] OP_DUMP = 8'h1D;
  localparam logic [15:0] OP_NOP = 16'h0000;

  localparam int SIZE_LSB = 6;
  localparam int CLASS_BIT = 3;
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_WORD = 2'h1;
  localparam logic [1:0] SZ_LONG = 2'h2;
  localparam logic [1:0] SZ_RSVD = 2'h3;

  localparam logic [2:0] EXT_REG_WR = 3'h2;
  localparam logic [2:0] EXT_MEM_RD = 3'h2;
  localparam logic [2:0] EXT_MEM_WR_SHORT = 3'h3;
  localparam logic [2:0] EXT_MEM_WR_LONG = 3'h4;

  typedef struct packed {
    logic status;
    logic [15:0] data;
  } dbgmc_resp_s;

  localparam dbgmc_resp_s RESP_DONE = '{1'b0, 16'hFFFF};
  localparam dbgmc_resp_s RESP_NOT_READY = '{1'b1, 16'h0000};
  localparam dbgmc_resp_s RESP_ILLEGAL = '{1'b1, 16'hFFFF};
  localparam dbgmc_resp_s RESP_BUS_ERR = '{1'b1, 16'h0001};

  typedef enum logic [1:0] {
    ST_CMD = 2'b00,
    ST_EXT = 2'b01,
    ST_BUSY = 2'b10,
    ST_RES2 = 2'b11
  } dbgmc_state_e;

  typedef enum logic [2:0] {
    K_NOP = 3'b000,
    K_RD_REG = 3'b001,
    K_WR_REG = 3'b010,
    K_MEM_RD = 3'b011,
    K_MEM_WR = 3'b100,
    K_DUMP = 3'b101,
    K_ILL = 3'b110
  } dbgmc_kind_e;

endpackage : dbgmc_pkg

// ==== dbgmc_top.sv ====
// Debug command engine: serial link, register and memory commands
module dbgmc_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic dsclk_i,
  input wire logic dsi_i,
  output logic dso_o,
  input wire logic cpu_halted_i,
  input wire logic [1:0] transfer_type_field_i,
  input wire logic [2:0] transfer_modifier_field_i,
  output logic [3:0] reg_sel_o,
  output logic reg_we_o,
  output logic [31:0] reg_wdata_o,
  input wire logic [31:0] reg_rdata_i,
  output logic bus_req_o,
  output logic bus_we_o,
  output logic [31:0] bus_addr_o,
  output logic [1:0] bus_size_o,
  output logic [31:0] bus_wdata_o,
  output logic [1:0] bus_tt_o,
  output logic [2:0] bus_tm_o,
  input wire logic bus_ack_i,
  input wire logic bus_err_i,
  input wire logic [31:0] bus_rdata_i
);

  function automatic dbgmc_pkg::dbgmc_kind_e cmd_kind(input logic [15:0] w);
    logic [1:0] sz;
    sz = w[dbgmc_pkg::SIZE_LSB +: 2];
    if (w == dbgmc_pkg::OP_NOP) begin
      cmd_kind = dbgmc_pkg::K_NOP;
    end else if (w[15:4] == dbgmc_pkg::OP_RD_REG) begin
      cmd_kind = dbgmc_pkg::K_RD_REG;
    end else if (w[15:4] == dbgmc_pkg::OP_WR_REG) begin
      cmd_kind = dbgmc_pkg::K_WR_REG;
    end else if (w[5:0] != 6'h00 || sz == dbgmc_pkg::SZ_RSVD) begin
      cmd_kind = dbgmc_pkg::K_ILL;
    end else if (w[15:8] == dbgmc_pkg::OP_MEM_RD) begin
      cmd_kind = dbgmc_pkg::K_MEM_RD;
    end else if (w[15:8] == dbgmc_pkg::OP_MEM_WR) begin
      cmd_kind = dbgmc_pkg::K_MEM_WR;
    end else if (w[15:8] == dbgmc_pkg::OP_DUMP) begin
      cmd_kind = dbgmc_pkg::K_DUMP;
    end else begin
      cmd_kind = dbgmc_pkg::K_ILL;
    end
  endfunction : cmd_kind

  function automatic logic [31:0] size_bytes(input logic [1:0] sz);
    case (sz)
      dbgmc_pkg::SZ_BYTE: size_bytes = 32'h00000001;
      dbgmc_pkg::SZ_WORD: size_bytes = 32'h00000002;
      default: size_bytes = 32'h00000004;
    endcase
  endfunction : size_bytes

  function automatic logic [31:0] align(input logic [31:0] a, input logic [1:0] sz);
    case (sz)
      dbgmc_pkg::SZ_BYTE: align = a;
      dbgmc_pkg::SZ_WORD: align = {a[31:1], 1'b0};
      default: align = {a[31:2], 2'h0};
    endcase
  endfunction : align

  // Link domain
  logic lrst_meta;
  logic lrst_reg;
  logic [4:0] bit_cnt_reg;
  logic [15:0] rx_shift_reg;
  logic [15:0] rx_word_reg;
  logic rx_tgl_reg;
  logic [15:0] tx_shift_reg;
  dbgmc_pkg::dbgmc_resp_s resp_reg;

  always_ff @(posedge dsclk_i) begin
    lrst_meta <= rst_i;
    lrst_reg <= lrst_meta;
  end

  always_ff @(posedge dsclk_i) begin
    if (lrst_reg) begin
      bit_cnt_reg <= 5'h00;
      rx_shift_reg <= 16'h0000;
      rx_word_reg <= 16'h0000;
      rx_tgl_reg <= 1'b0;
    end else begin
      rx_shift_reg <= {rx_shift_reg[14:0], dsi_i};
      if (bit_cnt_reg == dbgmc_pkg::FRAME_LAST) begin
        bit_cnt_reg <= 5'h00;
        rx_word_reg <= {rx_shift_reg[14:0], dsi_i};
        rx_tgl_reg <= ~rx_tgl_reg;
      end else begin
        bit_cnt_reg <= bit_cnt_reg + 5'h01;
      end
    end
  end

  always_ff @(posedge dsclk_i) begin
    if (lrst_reg) begin
      dso_o <= 1'b0;
      tx_shift_reg <= 16'h0000;
    end else if (bit_cnt_reg == 5'h00) begin
      dso_o <= resp_reg.status;
      tx_shift_reg <= resp_reg.data;
    end else begin
      dso_o <= tx_shift_reg[15];
      tx_shift_reg <= {tx_shift_reg[14:0], 1'b0};
    end
  end

  // Core domain
  logic rx_s1_reg;
  logic rx_s2_reg;
  logic rx_s3_reg;
  logic take;
  dbgmc_pkg::dbgmc_state_e state_reg;
  dbgmc_pkg::dbgmc_kind_e kind;
  dbgmc_pkg::dbgmc_kind_e op_reg;
  dbgmc_pkg::dbgmc_kind_e last_kind_reg;
  logic [1:0] size_reg;
  logic [2:0] ext_cnt_reg;
  logic [2:0] ext_need_reg;
  logic [63:0] ext_reg;
  logic [63:0] ext_next;
  logic ext_last;
  logic [31:0] result_reg;
  logic err_reg;
  logic done_reg;
  logic [31:0] temp_addr_reg;
  logic bus_done;
  logic start_go;
  logic start_we;
  logic [31:0] start_addr;
  logic [31:0] start_data;
  logic [1:0] start_size;
  logic [31:0] rd_reg;
  logic dump_ok;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_s1_reg <= 1'b0;
      rx_s2_reg <= 1'b0;
      rx_s3_reg <= 1'b0;
    end else begin
      rx_s1_reg <= rx_tgl_reg;
      rx_s2_reg <= rx_s1_reg;
      rx_s3_reg <= rx_s2_reg;
    end
  end

  assign take = rx_s2_reg ^ rx_s3_reg;
  assign kind = cmd_kind(rx_word_reg);
  assign ext_next = {ext_reg[47:0], rx_word_reg};
  assign ext_last = (ext_cnt_reg + 3'h1) == ext_need_reg;
  assign bus_done = bus_req_o && (bus_ack_i || bus_err_i);
  // block read needs last command a memory read, block read or NOP
  assign dump_ok = last_kind_reg == dbgmc_pkg::K_NOP || last_kind_reg == dbgmc_pkg::K_MEM_RD
                   || last_kind_reg == dbgmc_pkg::K_DUMP;
  localparam int CLASS_BIT_HI = dbgmc_pkg::CLASS_BIT;

  assign reg_sel_o = (state_reg == dbgmc_pkg::ST_CMD && !reg_we_o) ? rx_word_reg[CLASS_BIT_HI:0]
                     : ext_reg[CLASS_BIT_HI + 32 -: 4];

  always_comb begin
    start_go = 1'b0;
    start_we = 1'b0;
    start_addr = temp_addr_reg;
    start_data = 32'h00000000;
    start_size = rx_word_reg[dbgmc_pkg::SIZE_LSB +: 2];
    if (take && state_reg == dbgmc_pkg::ST_CMD && kind == dbgmc_pkg::K_DUMP && dump_ok) begin
      start_go = 1'b1;
    end else if (take && state_reg == dbgmc_pkg::ST_EXT && ext_last) begin
      start_size = size_reg;
      if (op_reg == dbgmc_pkg::K_MEM_RD) begin
        start_go = 1'b1;
        start_addr = ext_next[31:0];
      end else if (op_reg == dbgmc_pkg::K_MEM_WR) begin
        start_go = 1'b1;
        start_we = 1'b1;
        if (size_reg == dbgmc_pkg::SZ_LONG) begin
          start_addr = ext_next[63:32];
          start_data = ext_next[31:0];
        end else begin
          start_addr = ext_next[47:16];
          start_data = {16'h0000, ext_next[15:0]};
        end
      end
    end
  end

  // bus access with attributes and alignment
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_req_o <= 1'b0;
      bus_we_o <= 1'b0;
      bus_addr_o <= 32'h00000000;
      bus_size_o <= dbgmc_pkg::SZ_BYTE;
      bus_wdata_o <= 32'h00000000;
      bus_tt_o <= 2'h0;
      bus_tm_o <= 3'h0;
      rd_reg <= 32'h00000000;
    end else if (start_go) begin
      bus_req_o <= 1'b1;
      bus_we_o <= start_we;
      bus_addr_o <= align(start_addr, start_size);
      bus_size_o <= start_size;
      bus_wdata_o <= start_data;
      bus_tt_o <= transfer_type_field_i;
      bus_tm_o <= transfer_modifier_field_i;
    end else if (bus_done) begin
      bus_req_o <= 1'b0;
      rd_reg <= bus_rdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      temp_addr_reg <= 32'h00000000;
    end else if (bus_done && !bus_we_o) begin
      temp_addr_reg <= bus_addr_o + size_bytes(bus_size_o);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= dbgmc_pkg::ST_CMD;
      resp_reg <= dbgmc_pkg::RESP_DONE;
      op_reg <= dbgmc_pkg::K_NOP;
      last_kind_reg <= dbgmc_pkg::K_ILL;
      size_reg <= dbgmc_pkg::SZ_BYTE;
      ext_cnt_reg <= 3'h0;
      ext_need_reg <= 3'h0;
      ext_reg <= 64'h0;
      result_reg <= 32'h00000000;
      err_reg <= 1'b0;
      done_reg <= 1'b0;
      reg_we_o <= 1'b0;
      reg_wdata_o <= 32'h00000000;
    end else begin
      reg_we_o <= 1'b0;
      if (bus_done) begin
        done_reg <= 1'b1;
        err_reg <= bus_err_i;
      end
      case (state_reg)
        dbgmc_pkg::ST_CMD: begin
          if (take) begin
            op_reg <= kind;
            last_kind_reg <= kind;
            size_reg <= rx_word_reg[dbgmc_pkg::SIZE_LSB +: 2];
            ext_cnt_reg <= 3'h0;
            ext_reg <= {48'h0, rx_word_reg};
            case (kind)
              dbgmc_pkg::K_NOP: begin
                resp_reg <= dbgmc_pkg::RESP_DONE;
              end
              dbgmc_pkg::K_RD_REG: begin
                if (!cpu_halted_i) begin
                  resp_reg <= dbgmc_pkg::RESP_BUS_ERR;
                end else begin
                  resp_reg <= '{1'b0, reg_rdata_i[31:16]};
                  result_reg <= reg_rdata_i;
                  state_reg <= dbgmc_pkg::ST_RES2;
                end
              end
              dbgmc_pkg::K_WR_REG: begin
                ext_need_reg <= dbgmc_pkg::EXT_REG_WR;
                resp_reg <= dbgmc_pkg::RESP_NOT_READY;
                state_reg <= dbgmc_pkg::ST_EXT;
              end
              dbgmc_pkg::K_MEM_RD: begin
                ext_need_reg <= dbgmc_pkg::EXT_MEM_RD;
                resp_reg <= dbgmc_pkg::RESP_NOT_READY;
                state_reg <= dbgmc_pkg::ST_EXT;
              end
              dbgmc_pkg::K_MEM_WR: begin
                ext_need_reg <= rx_word_reg[dbgmc_pkg::SIZE_LSB +: 2] == dbgmc_pkg::SZ_LONG
                                ? dbgmc_pkg::EXT_MEM_WR_LONG : dbgmc_pkg::EXT_MEM_WR_SHORT;
                resp_reg <= dbgmc_pkg::RESP_NOT_READY;
                state_reg <= dbgmc_pkg::ST_EXT;
              end
              dbgmc_pkg::K_DUMP: begin
                if (dump_ok) begin
                  resp_reg <= dbgmc_pkg::RESP_NOT_READY;
                  done_reg <= 1'b0;
                  state_reg <= dbgmc_pkg::ST_BUSY;
                end else begin
                  resp_reg <= dbgmc_pkg::RESP_ILLEGAL;
                  last_kind_reg <= dbgmc_pkg::K_ILL;
                end
              end
              default: begin
                resp_reg <= dbgmc_pkg::RESP_ILLEGAL;
              end
            endcase
          end
        end
        dbgmc_pkg::ST_EXT: begin
          if (take) begin
            ext_reg <= ext_next;
            ext_cnt_reg <= ext_cnt_reg + 3'h1;
            resp_reg <= dbgmc_pkg::RESP_NOT_READY;
            if (ext_last) begin
              if (op_reg == dbgmc_pkg::K_WR_REG) begin
                state_reg <= dbgmc_pkg::ST_CMD;
                if (cpu_halted_i) begin
                  reg_we_o <= 1'b1;
                  reg_wdata_o <= ext_next[31:0];
                  resp_reg <= dbgmc_pkg::RESP_DONE;
                end else begin
                  resp_reg <= dbgmc_pkg::RESP_BUS_ERR;
                end
              end else begin
                done_reg <= 1'b0;
                state_reg <= dbgmc_pkg::ST_BUSY;
              end
            end
          end
        end
        dbgmc_pkg::ST_BUSY: begin
          if (take) begin
            resp_reg <= dbgmc_pkg::RESP_NOT_READY;
            if (done_reg || bus_done) begin
              if (err_reg || (bus_done && bus_err_i)) begin
                resp_reg <= dbgmc_pkg::RESP_BUS_ERR;
                state_reg <= dbgmc_pkg::ST_CMD;
              end else if (op_reg == dbgmc_pkg::K_MEM_WR) begin
                resp_reg <= dbgmc_pkg::RESP_DONE;
                state_reg <= dbgmc_pkg::ST_CMD;
              end else if (bus_size_o == dbgmc_pkg::SZ_LONG) begin
                resp_reg <= '{1'b0, rd_reg[31:16]};
                result_reg <= rd_reg;
                state_reg <= dbgmc_pkg::ST_RES2;
              end else if (bus_size_o == dbgmc_pkg::SZ_WORD) begin
                resp_reg <= '{1'b0, rd_reg[15:0]};
                state_reg <= dbgmc_pkg::ST_CMD;
              end else begin
                resp_reg <= '{1'b0, {8'h00, rd_reg[7:0]}};
                state_reg <= dbgmc_pkg::ST_CMD;
              end
            end
          end
        end
        dbgmc_pkg::ST_RES2: begin
          if (take) begin
            resp_reg <= '{1'b0, result_reg[15:0]};
            state_reg <= dbgmc_pkg::ST_CMD;
          end
        end
        default: begin
          state_reg <= dbgmc_pkg::ST_CMD;
        end
      endcase
    end
  end

  sequence s_cmd_taken;
    take && state_reg == dbgmc_pkg::ST_CMD;
  endsequence

  property p_illegal_nop;
    @(posedge clk_i) disable iff (rst_i)
      s_cmd_taken and kind == dbgmc_pkg::K_ILL |=>
        resp_reg == dbgmc_pkg::RESP_ILLEGAL && !bus_req_o && state_reg == dbgmc_pkg::ST_CMD;
  endproperty
  a_illegal_nop: assert property (p_illegal_nop) else $error("illegal command not refused");

  property p_reg_running;
    @(posedge clk_i) disable iff (rst_i)
      s_cmd_taken and kind == dbgmc_pkg::K_RD_REG and !cpu_halted_i |=>
        resp_reg == dbgmc_pkg::RESP_BUS_ERR;
  endproperty
  a_reg_running: assert property (p_reg_running) else $error("running read not bus error");

  property p_reg_upper;
    @(posedge clk_i) disable iff (rst_i)
      s_cmd_taken and kind == dbgmc_pkg::K_RD_REG and cpu_halted_i |=>
        resp_reg.data == $past(reg_rdata_i[31:16]) && !resp_reg.status;
  endproperty
  a_reg_upper: assert property (p_reg_upper) else $error("register upper word wrong");

  property p_align;
    @(posedge clk_i) disable iff (rst_i)
      bus_req_o && bus_size_o != dbgmc_pkg::SZ_BYTE |->
        bus_addr_o[0] == 1'b0 && (bus_size_o != dbgmc_pkg::SZ_LONG || bus_addr_o[1] == 1'b0);
  endproperty
  a_align: assert property (p_align) else $error("misaligned bus address");

  property p_attr;
    @(posedge clk_i) disable iff (rst_i)
      $rose(bus_req_o) |->
        bus_tt_o == $past(transfer_type_field_i) && bus_tm_o == $past(transfer_modifier_field_i);
  endproperty
  a_attr: assert property (p_attr) else $error("bus attributes not from fields");

  property p_dump_refused;
    @(posedge clk_i) disable iff (rst_i)
      s_cmd_taken and kind == dbgmc_pkg::K_DUMP and !dump_ok |=>
        resp_reg == dbgmc_pkg::RESP_ILLEGAL ##1 !bus_req_o;
  endproperty
  a_dump_refused: assert property (p_dump_refused) else $error("block read not refused");

  property p_nop_keeps;
    @(posedge clk_i) disable iff (rst_i)
      s_cmd_taken and kind == dbgmc_pkg::K_NOP |=> $stable(temp_addr_reg) && !resp_reg.status;
  endproperty
  a_nop_keeps: assert property (p_nop_keeps) else $error("nop disturbed block address");

  property p_advance;
    @(posedge clk_i) disable iff (rst_i)
      bus_done && !bus_we_o |=>
        temp_addr_reg == $past(bus_addr_o) + size_bytes($past(bus_size_o));
  endproperty
  a_advance: assert property (p_advance) else $error("block address not advanced");

  property p_busy_drop;
    @(posedge clk_i) disable iff (rst_i)
      take && state_reg == dbgmc_pkg::ST_BUSY && !done_reg && !bus_done |=>
        resp_reg == dbgmc_pkg::RESP_NOT_READY && state_reg == dbgmc_pkg::ST_BUSY;
  endproperty
  a_busy_drop: assert property (p_busy_drop) else $error("transfer during access not refused");

  property p_err_answer;
    @(posedge clk_i) disable iff (rst_i)
      take && state_reg == dbgmc_pkg::ST_BUSY && done_reg && err_reg |=>
        resp_reg == dbgmc_pkg::RESP_BUS_ERR && state_reg == dbgmc_pkg::ST_CMD;
  endproperty
  a_err_answer: assert property (p_err_answer) else $error("bus error answer wrong");

endmodule : dbgmc_top

// ==== dbgmc_host.sv ====
// Development system model driving the debug serial link
module dbgmc_host (
  output logic dsclk_o,
  output logic dsi_o,
  input wire logic dso_i
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    dsclk_o = 1'b0;
    dsi_o = 1'b0;
  end

  // Bare link clock edges
  task automatic pulses(input int n, input int half);
    repeat (n) begin
      #(half) dsclk_o = 1'b1;
      #(half) dsclk_o = 1'b0;
    end
  endtask : pulses

  task automatic xfer(input logic [15:0] w, output logic [16:0] r);
    logic [16:0] tx;
    tx = {1'b0, w};
    for (int i = 16; i >= 0; i--) begin
      dsi_o = tx[i];
      #40 dsclk_o = 1'b1;
      #40 dsclk_o = 1'b0;
      r[i] = dso_i;
    end
    // Released line shows the inverse of the last bit
    dsi_o = ~tx[0];
    #80;
  endtask : xfer
endmodule : dbgmc_host

// ==== tb.sv ====
// Self-checking bench of the debug command engine
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [16:0] NR = dbgmc_pkg::RESP_NOT_READY;
  localparam logic [16:0] DN = dbgmc_pkg::RESP_DONE;
  localparam logic [16:0] IL = dbgmc_pkg::RESP_ILLEGAL;
  localparam logic [16:0] BE = dbgmc_pkg::RESP_BUS_ERR;
  logic clk_i, rst_i, dsclk_i, dsi_i, dso_o, cpu_halted_i, reg_we_o;
  logic bus_req_o, bus_we_o, bus_ack_i, bus_err_i, ex_we, halted;
  logic [1:0] transfer_type_field_i, bus_size_o, bus_tt_o, ex_sz, tt_v;
  logic [2:0] transfer_modifier_field_i, bus_tm_o, tm_v;
  logic [3:0] reg_sel_o;
  logic [31:0] reg_wdata_o, reg_rdata_i, bus_addr_o, bus_wdata_o, bus_rdata_i;
  logic [31:0] ex_addr, ex_wd, ta;
  logic [31:0] cpu_regs [16];
  logic [31:0] exp_regs [16];
  logic [16:0] pend;
  logic [15:0] ill [4] = '{16'h19C0, 16'h1944, 16'h18C0, 16'hF000};
  int num_errors, compares, seed, cycles, wait_c;

  dbgmc_top dbgmc_top_inst (.clk_i, .rst_i, .dsclk_i, .dsi_i, .dso_o, .cpu_halted_i,
    .transfer_type_field_i, .transfer_modifier_field_i, .reg_sel_o, .reg_we_o,
    .reg_wdata_o, .reg_rdata_i, .bus_req_o, .bus_we_o, .bus_addr_o, .bus_size_o,
    .bus_wdata_o, .bus_tt_o, .bus_tm_o, .bus_ack_i, .bus_err_i, .bus_rdata_i);
  dbgmc_host dbgmc_host_inst (.dsclk_o(dsclk_i), .dsi_o(dsi_i), .dso_i(dso_o));

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  assign reg_rdata_i = cpu_regs[reg_sel_o];

  function automatic logic [31:0] pat(logic [31:0] a);
    return {~a[15:0], a[15:0]} ^ 32'h5A5A3C3C;
  endfunction : pat
  function automatic logic [31:0] aln(logic [31:0] a, logic [1:0] sz);
    return sz == 2'h2 ? {a[31:2], 2'h0} : (sz == 2'h1 ? {a[31:1], 1'h0} : a);
  endfunction : aln
  function automatic logic [31:0] msk(logic [1:0] sz);
    return sz == 2'h0 ? 32'hFF : (sz == 2'h1 ? 32'hFFFF : 32'hFFFFFFFF);
  endfunction : msk

  task automatic finish_test();
    $display("compares=%0d errors=%0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test

  task automatic chk_resp(input logic [16:0] g, input logic [16:0] e);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk_resp
  task automatic chk_val(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk_val

  // CPU side, attributes and cycle limit
  always @(posedge clk_i) begin
    cpu_halted_i <= halted;
    transfer_type_field_i <= tt_v;
    transfer_modifier_field_i <= tm_v;
    if (reg_we_o) cpu_regs[reg_sel_o] <= reg_wdata_o;
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      num_errors++;
      finish_test();
    end
  end

  // Memory responder, slow or prompt
  always @(posedge clk_i) begin
    bus_ack_i <= 1'b0;
    bus_err_i <= 1'b0;
    bus_rdata_i <= ~bus_rdata_i;
    if (bus_req_o && !bus_ack_i && !bus_err_i) begin
      if (wait_c == 0) begin
        chk_val(bus_addr_o, ex_addr);
        chk_val({bus_we_o, bus_size_o, bus_tt_o, bus_tm_o}, {ex_we, ex_sz, tt_v, tm_v});
        chk_val(bus_wdata_o & (ex_we ? msk(ex_sz) : 0), ex_wd & (ex_we ? msk(ex_sz) : 0));
        bus_err_i <= ex_addr[31:28] == 4'hE;
        bus_ack_i <= ex_addr[31:28] != 4'hE;
        bus_rdata_i <= pat(bus_addr_o);
        wait_c <= $random(seed) & 7;
      end else begin
        wait_c <= wait_c - 1;
      end
    end
  end

  task automatic frame(input logic [15:0] w, input logic [16:0] nxt);
    logic [16:0] r;
    dbgmc_host_inst.xfer(w, r);
    chk_resp(r, pend);
    pend = nxt;
  endtask : frame

  task automatic poll(input logic we, input logic [1:0] sz, input logic [31:0] a);
    logic [16:0] r;
    logic [16:0] e;
    logic [31:0] p;
    p = pat(a);
    frame(16'h0000, NR);
    r = NR;
    for (int i = 0; i < 20 && r === NR; i++) dbgmc_host_inst.xfer(16'h0000, r);
    pend = DN;
    if (a[31:28] == 4'hE) e = BE;
    else if (we) e = DN;
    else if (sz == 2'h2) begin
      e = {1'b0, p[31:16]};
      pend = {1'b0, p[15:0]};
    end else e = {1'b0, sz == 2'h0 ? {8'h00, p[7:0]} : p[15:0]};
    chk_resp(r, e);
  endtask : poll

  task automatic attr();
    tt_v = 2'($random(seed));
    tm_v = 3'($random(seed));
  endtask : attr

  task automatic mem(input logic we, input logic [1:0] sz, input logic [31:0] a,
                     input logic [31:0] d);
    attr();
    ex_we = we;
    ex_sz = sz;
    ex_addr = aln(a, sz);
    ex_wd = d;
    frame({we ? 8'h18 : 8'h19, sz, 6'h00}, NR);
    frame(a[31:16], NR);
    frame(a[15:0], NR);
    if (we && sz == 2'h2) frame(d[31:16], NR);
    if (we) frame(d[15:0], NR);
    poll(we, sz, ex_addr);
    ta = ex_addr + (32'h1 << sz);
  endtask : mem

  task automatic dump(input logic [1:0] sz);
    attr();
    ex_we = 1'b0;
    ex_sz = sz;
    ex_addr = aln(ta, sz);
    frame({8'h1D, sz, 6'h00}, NR);
    poll(1'b0, sz, ex_addr);
    ta = ex_addr + (32'h1 << sz);
  endtask : dump

  task automatic wr_reg(input logic [3:0] sel, input logic [31:0] d);
    frame({12'h208, sel}, NR);
    frame(d[31:16], NR);
    frame(d[15:0], halted ? DN : BE);
    if (halted) exp_regs[sel] = d;
  endtask : wr_reg

  task automatic rd_reg(input logic [3:0] sel);
    chk_val(cpu_regs[sel], exp_regs[sel]);
    if (halted) begin
      frame({12'h218, sel}, {1'b0, exp_regs[sel][31:16]});
      frame(16'h0000, {1'b0, exp_regs[sel][15:0]});
    end else frame({12'h218, sel}, BE);
  endtask : rd_reg

  initial begin
    seed = 32'h73e8c321;
    rst_i = 1'b1;
    {halted, cpu_halted_i, tt_v, tm_v, transfer_type_field_i} = '0;
    transfer_modifier_field_i = 3'h0;
    {bus_ack_i, bus_err_i, bus_rdata_i, ta} = '0;
    {num_errors, compares, cycles, wait_c} = '0;
    pend = DN;
    for (int i = 0; i < 16; i++) begin
      cpu_regs[i] = $random(seed);
      exp_regs[i] = cpu_regs[i];
    end
    fork
      repeat (20) @(posedge clk_i);
      #13 dbgmc_host_inst.pulses(2, 20);
    join
    rst_i <= 1'b0;
    dbgmc_host_inst.pulses(2, 40);
    frame(16'h1D40, IL);
    foreach (ill[i]) frame(ill[i], IL);
    $display("test illegal done");
    halted = 1'b1;
    wr_reg(4'h3, $random(seed));
    wr_reg(4'hD, $random(seed));
    rd_reg(4'h3);
    rd_reg(4'hD);
    $display("test halted registers done");
    halted = 1'b0;
    wr_reg(4'h3, $random(seed));
    rd_reg(4'h3);
    $display("test running registers done");
    for (int s = 0; s < 3; s++) mem(1'b0, 2'(s), {1'b0, 31'($random(seed))}, 0);
    $display("test memory reads done");
    mem(1'b0, 2'h2, {1'b0, 31'($random(seed))}, 0);
    dump(2'h1);
    frame(16'h0000, DN);
    dump(2'h2);
    dump(2'h0);
    $display("test block reads done");
    wr_reg(4'h1, $random(seed));
    frame(16'h1D40, IL);
    for (int s = 0; s < 3; s++) mem(1'b1, 2'(s), {1'b0, 31'($random(seed))}, $random(seed));
    mem(1'b1, 2'h1, 32'hE0000103, $random(seed));
    mem(1'b0, 2'h1, 32'hE0000007, 0);
    frame(16'h0000, DN);
    $display("test memory writes done");
    finish_test();
  end
endmodule : tb
